//--- hdl/pdfr_regs.svh
// constants of the power delivery packet framer host end
// assumes one 100 MHz clock, one line bit per clock cycle
`ifndef PDFR_REGS_SVH
`define PDFR_REGS_SVH

`define PDFR_CLK_MHZ      100
`define PDFR_PRE_BITS     7'h40
`define PDFR_K_SYNC1      5'h18
`define PDFR_K_SYNC2      5'h11
`define PDFR_K_SYNC3      5'h06
`define PDFR_K_RST1       5'h07
`define PDFR_K_RST2       5'h19
`define PDFR_K_EOP        5'h0d
`define PDFR_OS_BITS      6'h14
`define PDFR_CRC_BITS     6'h28
`define PDFR_SYM_BITS     6'h05
`define PDFR_BYTE_BITS    6'h0a
`define PDFR_CRC_POLY     32'h04c11db7
`define PDFR_CRC_SEED     32'hffffffff
`define PDFR_CRC_RESID    32'hc704dd7b
`define PDFR_CRC_BYTES    3'h4
`define PDFR_FIFO_DEPTH   8
`define PDFR_OS_MATCH_MIN 3'h3

`endif

//--- hdl/pdfr_pkg.sv
// types and coding functions of the packet framer host end
// assumes pdfr_regs.svh on the include path
`include "pdfr_regs.svh"

package pdfr_pkg;

  typedef enum logic [2:0] {
    PDFR_SOP    = 3'h0,
    PDFR_SOP_P  = 3'h1,
    PDFR_SOP_PP = 3'h2,
    PDFR_DBG_P  = 3'h3,
    PDFR_DBG_PP = 3'h4
  } pdfr_sop_t;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } pdfr_byte_t;

  typedef struct packed {
    pdfr_sop_t  sop;
    logic [7:0] data;
  } pdfr_rx_t;

  // first k-code in the low bits, it goes on the line first
  function automatic logic [19:0] pdfr_os(input pdfr_sop_t t);
    logic [19:0] r;
    r = {`PDFR_K_SYNC2, `PDFR_K_SYNC1, `PDFR_K_SYNC1, `PDFR_K_SYNC1};
    unique case (t)
      PDFR_SOP:    r = {`PDFR_K_SYNC2, {3{`PDFR_K_SYNC1}}};
      PDFR_SOP_P:  r = {{2{`PDFR_K_SYNC3}}, {2{`PDFR_K_SYNC1}}};
      PDFR_SOP_PP: r = {{2{`PDFR_K_SYNC3, `PDFR_K_SYNC1}}};
      PDFR_DBG_P:  r = {`PDFR_K_SYNC3, {2{`PDFR_K_RST2}}, `PDFR_K_SYNC1};
      PDFR_DBG_PP: r = {`PDFR_K_SYNC2, `PDFR_K_SYNC3, `PDFR_K_RST2,
                        `PDFR_K_SYNC1};
      default:     r = {`PDFR_K_SYNC2, {3{`PDFR_K_SYNC1}}};
    endcase
    return r;
  endfunction

  function automatic logic [4:0] pdfr_enc(input logic [3:0] n);
    logic [4:0] s;
    s = 5'h1e;
    unique case (n)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      4'hf: s = 5'h1d;
    endcase
    return s;
  endfunction

  // bit 4 of the result flags a hex data symbol
  function automatic logic [4:0] pdfr_dec(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (pdfr_enc(4'(i)) == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // crc runs bit 0 first over each byte
  function automatic logic [31:0] pdfr_crc(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[31] ^ b[i];
      r  = {r[30:0], 1'b0} ^ (fb ? `PDFR_CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  function automatic logic os_hit(input logic [19:0] w,
                                  input logic [19:0] os);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (w[5*i +: 5] == os[5*i +: 5]) begin
        n = n + 3'h1;
      end
    end
    return n >= `PDFR_OS_MATCH_MIN;
  endfunction

endpackage

//--- hdl/pdfr_fifo.sv
// small synchronous fifo with valid and ready on both sides
// assumes one clock; out_ready may stall, then in_ready falls
`timescale 1ns/10ps

module pdfr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              push;
  wire              pop;

  assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem_q[rp_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + (AW+1)'(1);
      end
      if (pop) begin
        rp_q <= rp_q + (AW+1)'(1);
      end
    end
  end

  // storage has no reset, only the pointers matter
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

endmodule

//--- hdl/pdfr_host.sv
// packet framer at the protocol-layer end of a power delivery line
// assumes a bit-serial modulator: one line bit per clock on transmit,
// a bit strobe and a frame envelope on receive
//
// Summary of operation
// RL1: line coding turns every four data bits into five symbol bits
// RL2: bits go least significant first, low nibble symbol before high
// RL3: frame order: preamble, start set, payload, crc, end marker
// RL4: modulator sends the whole coded frame, preamble included
// RL5: preamble is raw bits, never passed through the 4b5b coder
// RL6: preamble is 64 alternating bits, first zero, last one
// RL7: k-codes use the fixed sync, reset and end symbol values
// RL8: plain start set is three sync-1 then one sync-2
// RL9: a start set counts as valid with three of four codes right
// RL10: capable ports detect plain start sets, discard frames without one
// RL11: only port pairs exchange plain start packets, never cable plugs
// RL12: prime start set is two sync-1 then two sync-3
// RL13: a prime cable plug accepts only prime-started frames
// RL14: host port with prime accepts plain or prime, avoids collisions
// RL15: contracted device port neither sends nor accepts prime frames
// RL16: double prime start set is sync-1, sync-3, sync-1, sync-3
// RL17: double prime plug accepts only double prime frames
// RL18: double prime host port also supports prime, discards unknown starts
// RL19: device port never sends double prime, discards double prime frames
// RL20: two debug start sets exist and are told apart from others
// RL21: payload uses only the sixteen hex data symbols
// RL22: crc follows the last payload symbol with no gap
// RL23: exactly one end marker closes the crc field
// RL24: at the end marker the crc residual decides deliver or discard; code streams bytes out before it, sets only rx_crc_ok
// RL25: crc-32, poly 04c11db7, seed all ones, remainder complemented
// RL26: an early end marker cuts a frame; receiver sees a crc failure
// RL27: receiver reports the start set type with delivered data
`timescale 1ns/10ps
`include "pdfr_regs.svh"

module pdfr_host
  import pdfr_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire pdfr_byte_t tx_in,
  input  wire logic       tx_in_valid,
  output logic            tx_in_ready,
  input  wire logic       tx_start,
  input  wire pdfr_sop_t  tx_sop,
  input  wire logic       tx_abort,
  output logic            tx_busy,
  output logic            line_tx_bit,
  output logic            line_tx_en,
  input  wire logic       line_rx_bit,
  input  wire logic       line_rx_strobe,
  input  wire logic       line_rx_active,
  input  wire logic [4:0] rx_accept,
  output pdfr_rx_t        rx_out,
  output logic            rx_out_valid,
  output logic            rx_done,
  output logic            rx_crc_ok
);

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PRE  = 3'b001,
    TX_OS   = 3'b011,
    TX_DATA = 3'b010,
    TX_CRC  = 3'b110,
    TX_EOP  = 3'b111
  } pdfr_tx_st_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_DATA = 2'b01,
    RX_SKIP = 2'b11
  } pdfr_rx_st_t;

  // transmit side
  pdfr_tx_st_t tx_st_q;
  logic [6:0]  pre_cnt_q;
  logic [39:0] sh_q;
  logic [5:0]  bits_q;
  logic [31:0] tx_crc_q;
  logic        last_q;
  logic        abort_q;
  logic        line_tx_bit_q;
  logic        line_tx_en_q;
  pdfr_byte_t  fifo_out;
  logic        fifo_valid;
  wire         sym_end;
  wire         want_byte;
  wire         pop;
  wire  [31:0] crc_field;
  wire  [39:0] crc_syms;
  wire  [9:0]  byte_syms;

  pdfr_fifo #(
    .WIDTH ($bits(pdfr_byte_t)),
    .DEPTH (`PDFR_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_data   (tx_in),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  assign sym_end   = bits_q == 6'h01;
  assign want_byte = (tx_st_q == TX_OS || tx_st_q == TX_DATA) && sym_end
                     && !last_q;
  // RL26 early end
  assign pop       = want_byte && !abort_q && fifo_valid;
  // RL25 complement and map
  assign crc_field = {<<{~tx_crc_q}};
  // RL2 low nibble first
  assign byte_syms = {pdfr_enc(fifo_out.data[7:4]),
                      pdfr_enc(fifo_out.data[3:0])};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_crc_enc
      assign crc_syms[5*gi +: 5] = pdfr_enc(crc_field[4*gi +: 4]);
    end
  endgenerate

  assign tx_busy     = tx_st_q != TX_IDLE;
  assign line_tx_bit = line_tx_bit_q;
  assign line_tx_en  = line_tx_en_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      abort_q <= 1'b0;
    end else begin
      // a new abort wins over the idle clear
      abort_q <= tx_abort || (abort_q && tx_st_q != TX_IDLE);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_st_q       <= TX_IDLE;
      pre_cnt_q     <= 7'h00;
      sh_q          <= '0;
      bits_q        <= 6'h00;
      tx_crc_q      <= `PDFR_CRC_SEED;
      last_q        <= 1'b0;
      line_tx_bit_q <= 1'b0;
      line_tx_en_q  <= 1'b0;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          line_tx_bit_q <= 1'b0;
          line_tx_en_q  <= 1'b0;
          pre_cnt_q     <= 7'h00;
          last_q        <= 1'b0;
          tx_crc_q      <= `PDFR_CRC_SEED;
          if (tx_start) begin
            tx_st_q <= TX_PRE;
          end
        end
        TX_PRE: begin
          // RL5 raw bits
          // RL6 alternating, zero first
          line_tx_bit_q <= pre_cnt_q[0];
          line_tx_en_q  <= 1'b1;
          pre_cnt_q     <= pre_cnt_q + 7'h01;
          if (pre_cnt_q == `PDFR_PRE_BITS - 7'h01) begin
            // RL3 start set follows
            // RL8 RL12 RL16 RL20 set by type
            sh_q    <= {20'h00000, pdfr_os(tx_sop)};
            bits_q  <= `PDFR_OS_BITS;
            tx_st_q <= TX_OS;
          end
        end
        default: begin
          // RL4 one bit per clock to modulator
          line_tx_bit_q <= sh_q[0];
          sh_q          <= {1'b0, sh_q[39:1]};
          bits_q        <= bits_q - 6'h01;
          if (sym_end) begin
            if (tx_st_q == TX_EOP) begin
              tx_st_q <= TX_IDLE;
            end else if (tx_st_q == TX_CRC || (want_byte && !pop)) begin
              // RL7 RL23 single end marker
              sh_q    <= {35'h0, `PDFR_K_EOP};
              bits_q  <= `PDFR_SYM_BITS;
              tx_st_q <= TX_EOP;
            end else if (last_q) begin
              // RL22 crc right after payload
              sh_q    <= crc_syms;
              bits_q  <= `PDFR_CRC_BITS;
              tx_st_q <= TX_CRC;
            end else begin
              // RL1 ten bits a byte
              // RL21 hex symbols only
              sh_q     <= {30'h0, byte_syms};
              bits_q   <= `PDFR_BYTE_BITS;
              tx_crc_q <= pdfr_crc(tx_crc_q, fifo_out.data);
              last_q   <= fifo_out.last;
              tx_st_q  <= TX_DATA;
            end
          end
        end
      endcase
    end
  end

  // receive side
  pdfr_rx_st_t rx_st_q;
  logic [19:0] win_q;
  logic [2:0]  rx_bit_q;
  logic        half_q;
  logic [3:0]  lo_q;
  logic [31:0] rx_crc_q;
  logic [2:0]  nbytes_q;
  logic [7:0]  dly_q [4];
  logic [1:0]  dwp_q;
  pdfr_sop_t   rx_sop_q;
  pdfr_rx_t    rx_out_q;
  logic        rx_out_valid_q;
  logic        rx_done_q;
  logic        rx_ok_q;
  wire  [19:0] win_d;
  wire  [4:0]  hit;
  wire         any_hit;
  pdfr_sop_t   hit_sop;
  wire  [4:0]  sym;
  wire  [4:0]  dec;
  wire         sym_rdy;
  wire         is_eop;
  wire  [7:0]  rx_byte;
  wire         good_end;

  assign win_d = {line_rx_bit, win_q[19:1]};

  generate
    for (gi = 0; gi < 5; gi++) begin : g_hit
      // RL9 three of four
      assign hit[gi] = os_hit(win_d, pdfr_os(pdfr_sop_t'(gi)));
    end
  endgenerate

  assign any_hit  = |hit;
  assign hit_sop  = hit[0] ? PDFR_SOP :
                    hit[1] ? PDFR_SOP_P :
                    hit[2] ? PDFR_SOP_PP :
                    hit[3] ? PDFR_DBG_P : PDFR_DBG_PP;
  assign sym      = win_d[19:15];
  assign dec      = pdfr_dec(sym);
  assign sym_rdy  = line_rx_strobe && rx_bit_q == 3'h4;
  assign is_eop   = sym == `PDFR_K_EOP;
  assign rx_byte  = {dec[3:0], lo_q};
  // RL24 residual check
  // RL26 cut frames fail here
  assign good_end = !half_q && nbytes_q == `PDFR_CRC_BYTES
                    && rx_crc_q == `PDFR_CRC_RESID;

  assign rx_out       = rx_out_q;
  assign rx_out_valid = rx_out_valid_q;
  assign rx_done      = rx_done_q;
  assign rx_crc_ok    = rx_ok_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_st_q        <= RX_HUNT;
      win_q          <= '0;
      rx_bit_q       <= 3'h0;
      half_q         <= 1'b0;
      lo_q           <= 4'h0;
      rx_crc_q       <= `PDFR_CRC_SEED;
      nbytes_q       <= 3'h0;
      dwp_q          <= 2'h0;
      dly_q          <= '{default: 8'h00};
      rx_sop_q       <= PDFR_SOP;
      rx_out_q       <= '0;
      rx_out_valid_q <= 1'b0;
      rx_done_q      <= 1'b0;
      rx_ok_q        <= 1'b0;
    end else begin
      rx_out_valid_q <= 1'b0;
      rx_done_q      <= 1'b0;
      if (line_rx_strobe) begin
        win_q    <= win_d;
        rx_bit_q <= (rx_bit_q == 3'h4) ? 3'h0 : rx_bit_q + 3'h1;
      end
      unique case (rx_st_q)
        RX_HUNT: begin
          if (line_rx_strobe && any_hit) begin
            // RL10 RL11 RL13 RL14 RL15 RL17 RL18 RL19 accept mask
            rx_st_q  <= rx_accept[hit_sop] ? RX_DATA : RX_SKIP;
            rx_sop_q <= hit_sop;
            rx_bit_q <= 3'h0;
            half_q   <= 1'b0;
            nbytes_q <= 3'h0;
            rx_crc_q <= `PDFR_CRC_SEED;
          end
        end
        RX_DATA: begin
          if (!line_rx_active) begin
            rx_done_q <= 1'b1;
            rx_ok_q   <= 1'b0;
            rx_st_q   <= RX_HUNT;
          end else if (sym_rdy && is_eop) begin
            rx_done_q <= 1'b1;
            rx_ok_q   <= good_end;
            rx_st_q   <= RX_SKIP;
          end else if (sym_rdy && !dec[4]) begin
            rx_done_q <= 1'b1;
            rx_ok_q   <= 1'b0;
            rx_st_q   <= RX_SKIP;
          end else if (sym_rdy && !half_q) begin
            lo_q   <= dec[3:0];
            half_q <= 1'b1;
          end else if (sym_rdy) begin
            // last four bytes are the crc, held back
            half_q        <= 1'b0;
            rx_crc_q      <= pdfr_crc(rx_crc_q, rx_byte);
            dly_q[dwp_q]  <= rx_byte;
            dwp_q         <= dwp_q + 2'h1;
            rx_out_valid_q <= nbytes_q == `PDFR_CRC_BYTES;
            // RL27 type with each byte
            rx_out_q      <= '{sop: rx_sop_q, data: dly_q[dwp_q]};
            if (nbytes_q != `PDFR_CRC_BYTES) begin
              nbytes_q <= nbytes_q + 3'h1;
            end
          end
        end
        RX_SKIP: begin
          if (!line_rx_active) begin
            rx_st_q <= RX_HUNT;
          end
        end
      endcase
    end
  end

  // RL6 preamble start
  AST_PRE_FIRST: assert property (@(posedge clock) disable iff (rst)
    (tx_st_q == TX_PRE && pre_cnt_q == 7'h00) |=>
      (line_tx_en && !line_tx_bit))
    else $error("preamble does not start with zero");

  // RL6 preamble alternates
  AST_PRE_ALT: assert property (@(posedge clock) disable iff (rst)
    (tx_st_q == TX_PRE && pre_cnt_q != 7'h00) |=>
      (line_tx_bit != $past(line_tx_bit)))
    else $error("preamble bits do not alternate");

  // RL3 preamble then start set
  AST_PRE_LEN: assert property (@(posedge clock) disable iff (rst)
    ($rose(tx_st_q == TX_PRE)) |-> ##64 (tx_st_q == TX_OS))
    else $error("preamble length is not 64 bits");

  // RL8 start set length
  AST_OS_LEN: assert property (@(posedge clock) disable iff (rst)
    $rose(tx_st_q == TX_OS) |-> (tx_st_q == TX_OS) [*8] ##13
      (tx_st_q == TX_DATA || tx_st_q == TX_EOP))
    else $error("start set is not twenty bits");

  // RL22 crc field length
  AST_CRC_LEN: assert property (@(posedge clock) disable iff (rst)
    $rose(tx_st_q == TX_CRC) |-> ##40 (tx_st_q == TX_EOP))
    else $error("crc field is not forty bits");

  // RL23 end marker bits
  AST_EOP_SYM: assert property (@(posedge clock) disable iff (rst)
    $rose(tx_st_q == TX_EOP) |=> line_tx_bit ##1 !line_tx_bit
      ##1 line_tx_bit ##1 line_tx_bit ##1 !line_tx_bit ##1 !line_tx_en)
    else $error("end marker symbol is wrong");

  // RL24 verdict tied to residual
  AST_RX_OK: assert property (@(posedge clock) disable iff (rst)
    (rx_done && rx_crc_ok) |-> ($past(rx_crc_q) == `PDFR_CRC_RESID))
    else $error("packet passed with bad crc residual");

  // RL10 filtered types never delivered
  AST_RX_FILT: assert property (@(posedge clock) disable iff (rst)
    rx_out_valid |-> rx_accept[rx_out.sop] || $past(rx_accept) != rx_accept)
    else $error("data delivered for a refused start set");

endmodule

//--- verification/pdfr_line_model.sv
// line partner: a remote phy that frames, sends and captures bits
// assumes one line bit per clock on transmit; drives at falling edges
`timescale 1ns/10ps
`include "pdfr_regs.svh"

module pdfr_line_model (
  input  wire logic clock,
  input  wire logic line_tx_bit,
  input  wire logic line_tx_en,
  output logic      line_rx_bit,
  output logic      line_rx_strobe,
  output logic      line_rx_active
);
  localparam logic [4:0] S1 = `PDFR_K_SYNC1;
  localparam logic [4:0] S2 = `PDFR_K_SYNC2;
  localparam logic [4:0] S3 = `PDFR_K_SYNC3;
  localparam logic [4:0] R2 = `PDFR_K_RST2;
  localparam logic [4:0] OSK [5][4] = '{'{S1, S1, S1, S2},
    '{S1, S1, S3, S3}, '{S1, S3, S1, S3}, '{S1, R2, R2, S3},
    '{S1, R2, S3, S2}};
  localparam logic [4:0] HEX [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
    5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a,
    5'h1b, 5'h1c, 5'h1d};
  logic [7:0] dat[$];
  logic       fq[$];
  logic       cap[$];

  initial begin
    line_rx_bit    = 1'b0;
    line_rx_strobe = 1'b0;
    line_rx_active = 1'b0;
  end

  always @(posedge clock) begin
    if (line_tx_en === 1'b1) begin
      cap.push_back(line_tx_bit);
    end
  end

  function automatic void sym(input logic [4:0] s);
    for (int i = 0; i < 5; i++) begin
      fq.push_back(s[i]);
    end
  endfunction

  function automatic void byt(input logic [7:0] b);
    sym(HEX[b[3:0]]);
    sym(HEX[b[7:4]]);
  endfunction

  // crc over each byte, bit 0 first
  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0]  b);
    for (int i = 0; i < 8; i++) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? `PDFR_CRC_POLY : 32'h0);
    end
    return c;
  endfunction

  // frame assembly
  // mode 0 good, 1 bad crc, 2 cut after data, 3 bad symbol at end
  // cm marks corrupt codes
  function automatic void build(input int k, input logic [3:0] cm,
                                input int mode);
    logic [31:0] c;
    logic [31:0] f;
    c = `PDFR_CRC_SEED;
    fq.delete();
    for (int i = 0; i < 64; i++) begin
      fq.push_back(i[0]);
    end
    for (int i = 0; i < 4; i++) begin
      sym(cm[i] ? 5'h00 : OSK[k][i]);
    end
    foreach (dat[i]) begin
      byt(dat[i]);
      c = crc8(c, dat[i]);
    end
    f = {<<{~c}};
    f[0] = f[0] ^ (mode == 1);
    if (mode != 2) begin
      for (int i = 0; i < 4; i++) begin
        byt(f[8*i +: 8]);
      end
    end
    if (mode == 3) begin
      sym(5'h00);
    end
    sym(`PDFR_K_EOP);
  endfunction

  // gap 0 sends a bit each clock; the line toggles while stalled
  task automatic send(input int gap);
    line_rx_active = 1'b1;
    foreach (fq[i]) begin
      @(negedge clock);
      line_rx_bit    = fq[i];
      line_rx_strobe = 1'b1;
      repeat (gap) begin
        @(negedge clock);
        line_rx_strobe = 1'b0;
        line_rx_bit    = ~line_rx_bit;
      end
    end
    @(negedge clock);
    line_rx_strobe = 1'b0;
    line_rx_bit    = ~line_rx_bit;
    repeat (3) @(negedge clock);
    line_rx_active = 1'b0;
  endtask
endmodule

//--- verification/test_pd_packet_framer.sv
// bench for the packet framer host end against a line partner
// assumes the package, design and line model are compiled first
`timescale 1ns/10ps
`include "pdfr_regs.svh"

module test_pd_packet_framer
  import pdfr_pkg::*;
;
  logic       clock;
  logic       rst;
  pdfr_byte_t tx_in;
  logic       tx_in_valid;
  logic       tx_in_ready;
  logic       tx_start;
  pdfr_sop_t  tx_sop;
  logic       tx_abort;
  logic       tx_busy;
  logic       line_tx_bit;
  logic       line_tx_en;
  logic       line_rx_bit;
  logic       line_rx_strobe;
  logic       line_rx_active;
  logic [4:0] rx_accept;
  pdfr_rx_t   rx_out;
  logic       rx_out_valid;
  logic       rx_done;
  logic       rx_crc_ok;
  pdfr_rx_t   rxq[$];
  int         done_cnt;
  logic       ok_seen;
  int         error_cnt;
  int         cmp_count;

  pdfr_host dut_u (.clock(clock), .rst(rst), .tx_in(tx_in),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_start(tx_start), .tx_sop(tx_sop), .tx_abort(tx_abort),
    .tx_busy(tx_busy), .line_tx_bit(line_tx_bit),
    .line_tx_en(line_tx_en), .line_rx_bit(line_rx_bit),
    .line_rx_strobe(line_rx_strobe), .line_rx_active(line_rx_active),
    .rx_accept(rx_accept), .rx_out(rx_out), .rx_out_valid(rx_out_valid),
    .rx_done(rx_done), .rx_crc_ok(rx_crc_ok));

  pdfr_line_model model_u (.clock(clock), .line_tx_bit(line_tx_bit),
    .line_tx_en(line_tx_en), .line_rx_bit(line_rx_bit),
    .line_rx_strobe(line_rx_strobe), .line_rx_active(line_rx_active));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (rx_out_valid === 1'b1) begin
      rxq.push_back(rx_out);
    end
    if (rx_done === 1'b1) begin
      done_cnt++;
      ok_seen = rx_crc_ok;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // valid held until the edge that sees ready
  task automatic push(input logic l, input logic [7:0] d);
    @(negedge clock);
    tx_in       = '{last: l, data: d};
    tx_in_valid = 1'b1;
    for (int n = 0; n < 100 && tx_in_ready !== 1'b1; n++) begin
      @(negedge clock);
    end
    check(32'(tx_in_ready), 32'h1);
    @(posedge clock);
  endtask

  task automatic load(input logic cut);
    foreach (model_u.dat[i]) begin
      push(!cut && i == model_u.dat.size() - 1, model_u.dat[i]);
    end
    @(negedge clock);
    tx_in_valid = 1'b0;
  endtask

  task automatic run_tx(input int k);
    model_u.cap.delete();
    @(negedge clock);
    tx_sop   = pdfr_sop_t'(k);
    tx_start = 1'b1;
    @(negedge clock);
    tx_start = 1'b0;
    check(32'(tx_busy), 32'h1);
    for (int n = 0; n < 3000 && tx_busy === 1'b1; n++) begin
      @(negedge clock);
    end
    check(32'(tx_busy), 32'h0);
    repeat (3) @(negedge clock);
  endtask

  task automatic cmp_tx();
    int bad;
    bad = 0;
    foreach (model_u.fq[i]) begin
      if (model_u.cap[i] !== model_u.fq[i]) bad++;
    end
    check(model_u.cap.size(), model_u.fq.size());
    check(bad, 0);
  endtask

  task automatic rx(input int k, input logic [3:0] cm, input int mode,
                    input logic [4:0] mask, input int gap);
    rx_accept = mask;
    rxq.delete();
    done_cnt = 0;
    model_u.build(k, cm, mode);
    @(negedge clock);
    model_u.send(gap);
    repeat (4) @(negedge clock);
  endtask

  task automatic t_tx_types();
    for (int k = 0; k < 5; k++) begin
      model_u.dat = '{8'h5a ^ 8'(k), 8'h0f, 8'hc3};
      load(1'b0);
      model_u.build(k, 4'h0, 0);
      run_tx(k);
      cmp_tx();
    end
    $display("test tx_types done");
  endtask

  task automatic t_fifo();
    model_u.dat.delete();
    for (int i = 0; i < 8; i++) begin
      model_u.dat.push_back(8'h1d * 8'(i));
    end
    load(1'b0);
    @(negedge clock);
    tx_in_valid = 1'b1;
    check(32'(tx_in_ready), 32'h0);
    @(negedge clock);
    tx_in_valid = 1'b0;
    model_u.build(0, 4'h0, 0);
    run_tx(0);
    cmp_tx();
    check(32'(tx_in_ready), 32'h1);
    $display("test fifo done");
  endtask

  task automatic t_cut();
    model_u.dat = '{8'hc3};
    load(1'b1);
    model_u.build(1, 4'h0, 2);
    run_tx(1);
    cmp_tx();
    $display("test cut done");
  endtask

  task automatic t_rx_types();
    for (int k = 0; k < 5; k++) begin
      model_u.dat = '{8'h96, 8'h0f + 8'(k)};
      rx(k, 4'h2 << (k % 3), 0, 5'h1f, 2 * (k % 2));
      check(done_cnt, 1);
      check(32'(ok_seen), 32'h1);
      check(rxq.size(), 2);
      foreach (rxq[i]) begin
        check(32'(rxq[i].data), 32'(model_u.dat[i]));
        check(32'(rxq[i].sop), 32'(k));
      end
    end
    $display("test rx_types done");
  endtask

  task automatic none();
    check(rxq.size() + done_cnt, 0);
  endtask

  task automatic t_rx_filter();
    model_u.dat = '{8'h11, 8'h7e};
    rx(0, 4'h0, 0, 5'h02, 0);
    none();
    rx(2, 4'h0, 0, 5'h01, 1);
    none();
    rx(1, 4'h0, 0, 5'h01, 0);
    none();
    rx(1, 4'ha, 0, 5'h1f, 0);
    none();
    rx(1, 4'h0, 0, 5'h03, 0);
    check(rxq.size(), 2);
    $display("test rx_filter done");
  endtask

  task automatic t_rx_bad();
    model_u.dat = '{8'h01, 8'h80, 8'hff};
    rx(0, 4'h0, 1, 5'h1f, 1);
    check({done_cnt[30:0], ok_seen}, 32'h2);
    rx(0, 4'h0, 2, 5'h1f, 0);
    check({done_cnt[30:0], ok_seen}, 32'h2);
    rx(0, 4'h0, 3, 5'h1f, 0);
    check({done_cnt[30:0], ok_seen}, 32'h2);
    $display("test rx_bad done");
  endtask

  task automatic t_abort();
    logic [4:0] e;
    model_u.dat = '{8'h12, 8'h34, 8'h56};
    load(1'b0);
    model_u.build(0, 4'h0, 0);
    fork
      run_tx(0);
      begin
        repeat (20) @(negedge clock);
        tx_abort = 1'b1;
        @(negedge clock);
        tx_abort = 1'b0;
      end
    join
    for (int i = 0; i < 5; i++) begin
      e[i] = model_u.cap[model_u.cap.size() - 5 + i];
    end
    check(32'(e), 32'(`PDFR_K_EOP));
    check(model_u.cap.size() < model_u.fq.size(), 1);
    $display("test abort done");
  endtask

  initial begin
    #500000;
    error_cnt++;
    conclude();
  end

  initial begin
    rst         = 1'b1;
    tx_in       = '0;
    tx_in_valid = 1'b0;
    tx_start    = 1'b0;
    tx_sop      = PDFR_SOP;
    tx_abort    = 1'b0;
    rx_accept   = 5'h1f;
    error_cnt   = 0;
    cmp_count   = 0;
    done_cnt    = 0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    t_tx_types();
    t_fifo();
    t_cut();
    t_rx_types();
    t_rx_filter();
    t_rx_bad();
    // abort leaves bytes in the fifo, so it runs last
    t_abort();
    conclude();
  end
endmodule
